// File: verilog/ext_irq_top.sv
// top: apb register slave, break protection and cpu-facing request for the external interrupt
//
// Overview of operation
// - falling pin edge sets request latch
// - vector fetch acknowledge clears the latch
// - writing one to ack clears latch
// - reset clears latch and sensitivity bit
// - edge mode: latch holds until acknowledged
// - level mode: needs ack and pin high
// - level mode: pending while pin low
// - mask bit withholds request from cpu
// - pending flag reads request, ignores mask
// - ack bit write-only, reads zero
// - mask bit read/write, reset clears
// - sensitivity bit read/write, reset zero
// - later falling edges latch new request
// - serviced request vectors from fixed location
// - break clear enable lets acks work
// - otherwise acks ignored during break
// - cpu global mask also blocks request
// - pin level offered to branch instructions
`timescale 1ns/10ps
module ext_irq_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic irq_pin_n,
  input wire logic vector_fetch,
  input wire logic break_state,
  input wire logic global_mask,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic cpu_irq_req,
  output logic [15:0] cpu_vector_addr,
  output logic pin_level,
  output logic irq
);
  ext_irq_if ctl_if ();
  logic sync_level;
  logic sync_fall;
  logic mode_r;
  logic mask_r;
  logic break_clear_r;
  logic ack_r;
  logic [ext_irq_pkg::ev_width-1:0] ev_status_r;
  logic [ext_irq_pkg::ev_width-1:0] ev_mask_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic req_r;
  logic level_r;
  logic irq_r;
  logic pending_prev_r;
  logic [15:0] vec_r;

  pin_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_n(irq_pin_n),
    .level(sync_level),
    .fall(sync_fall)
  );

  irq_latch u_latch (
    .ref_clk(ref_clk),
    .rst(rst),
    .fall(sync_fall),
    .level(sync_level),
    .vector_fetch(vector_fetch),
    .ctl(ctl_if.latch)
  );

  // bus decode; single-cycle access phase, pready high with penable
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire setup = psel & ~penable;
  wire rd_setup = setup & ~pwrite;
  wire hit_sc = (paddr == ext_irq_pkg::status_control_addr);
  wire hit_st = (paddr == ext_irq_pkg::irq_status_addr);
  wire hit_mk = (paddr == ext_irq_pkg::irq_mask_addr);
  wire hit_bk = (paddr == ext_irq_pkg::break_ctrl_addr);
  wire hit_vc = (paddr == ext_irq_pkg::vector_addr);
  wire hit_any = hit_sc | hit_st | hit_mk | hit_bk | hit_vc;
  wire wr_sc = wr & hit_sc;
  wire ack_wr = wr_sc & pwdata[ext_irq_pkg::ack_pos];
  // during break the ack only works if clearing is enabled
  wire ack_ok = ack_wr & (~break_state | break_clear_r);
  wire pending = ctl_if.pending;
  wire latch_rise = pending & ~pending_prev_r;

  wire [ext_irq_pkg::ev_width-1:0] ev_set = {ack_ok, latch_rise};
  wire [ext_irq_pkg::ev_width-1:0] ev_clr = (wr & hit_st)
      ? pwdata[ext_irq_pkg::ev_width-1:0] : ext_irq_pkg::ev_reset;

  function automatic logic [31:0] sc_word(input logic pend, input logic msk, input logic md);
    logic [31:0] w;
    w = ext_irq_pkg::rd_zero;
    w[ext_irq_pkg::pending_pos] = pend;
    w[ext_irq_pkg::mask_pos] = msk;
    w[ext_irq_pkg::mode_pos] = md;
    return w; // ack position stays zero
  endfunction

  wire [31:0] rd_mux =
      hit_sc ? sc_word(pending, mask_r, mode_r) :
      hit_st ? {30'h0, ev_status_r} :
      hit_mk ? {30'h0, ev_mask_r} :
      hit_bk ? {31'h0, break_clear_r} :
      hit_vc ? {16'h0000, ext_irq_pkg::vector_location} :
      ext_irq_pkg::rd_zero;

  assign ctl_if.mode = mode_r;
  assign ctl_if.ack = ack_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_r <= 1'b0;
      mask_r <= 1'b0;
      break_clear_r <= 1'b0;
      ack_r <= 1'b0;
    end else begin
      ack_r <= ack_ok;
      if (wr_sc) begin
        mode_r <= pwdata[ext_irq_pkg::mode_pos];
        mask_r <= pwdata[ext_irq_pkg::mask_pos];
      end
      if (wr & hit_bk) begin
        break_clear_r <= pwdata[ext_irq_pkg::break_clear_pos];
      end
    end
  end

  // set wins over a same-cycle write-one clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ev_status_r <= ext_irq_pkg::ev_reset;
      ev_mask_r <= ext_irq_pkg::ev_reset;
      pending_prev_r <= 1'b0;
    end else begin
      ev_status_r <= (ev_status_r & ~ev_clr) | ev_set;
      pending_prev_r <= pending;
      if (wr & hit_mk) begin
        ev_mask_r <= pwdata[ext_irq_pkg::ev_width-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata_r <= ext_irq_pkg::rd_zero;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= rd_setup ? rd_mux : prdata_r;
      pready_r <= setup;
      pslverr_r <= setup & ~hit_any;
    end
  end

  // cpu-facing outputs, all registered
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      req_r <= 1'b0;
      level_r <= 1'b1;
      irq_r <= 1'b0;
      vec_r <= ext_irq_pkg::vector_location;
    end else begin
      vec_r <= ext_irq_pkg::vector_location;
      req_r <= pending & ~mask_r & ~global_mask;
      level_r <= sync_level;
      irq_r <= |(ev_status_r & ev_mask_r);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign cpu_irq_req = req_r;
  assign cpu_vector_addr = vec_r;
  assign pin_level = level_r;
  assign irq = irq_r;
endmodule

// File: verilog/ext_irq_pkg.sv
// package: register map, field positions and reset values of the external interrupt unit
package ext_irq_pkg;
  localparam logic [11:0] status_control_addr = 12'h000;
  localparam logic [11:0] irq_status_addr = 12'h004;
  localparam logic [11:0] irq_mask_addr = 12'h008;
  localparam logic [11:0] break_ctrl_addr = 12'h00c;
  localparam logic [11:0] vector_addr = 12'h010;
  // bit positions in the status/control byte
  localparam int mode_pos = 0;
  localparam int mask_pos = 1;
  localparam int ack_pos = 2;
  localparam int pending_pos = 3;
  // bit positions in the irq status and irq mask registers
  localparam int ev_latch_pos = 0;
  localparam int ev_ack_pos = 1;
  localparam int ev_width = 2;
  localparam int break_clear_pos = 0;
  localparam logic [15:0] vector_location = 16'hfffa;
  localparam logic [ev_width-1:0] ev_reset = 2'h0;
  localparam logic [31:0] rd_zero = 32'h0000_0000;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_pending = 2'b01,
    st_wait_high = 2'b11
  } latch_state_e;
endpackage

// File: verilog/ext_irq_if.sv
// interface: handshake between register front end and the request latch
`timescale 1ns/10ps
interface ext_irq_if;
  logic mode;
  logic ack;
  logic pending;
  modport regs (output mode, output ack, input pending);
  modport latch (input mode, input ack, output pending);
endinterface

// File: verilog/pin_sync.sv
// two-stage synchroniser and falling-edge detector for the interrupt pin
`timescale 1ns/10ps
module pin_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin_n,
  output logic level,
  output logic fall
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic warm_a_r;
  logic warm_b_r;
  logic armed_r;
  // stages reset high so the level reads idle; the edge detector stays blind until
  // prev holds a real sample, else a pin held low through reset would relatch
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
      warm_a_r <= 1'b0;
      warm_b_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      meta_r <= pin_n;
      sync_r <= meta_r;
      prev_r <= sync_r;
      warm_a_r <= 1'b1;
      warm_b_r <= warm_a_r;
      armed_r <= warm_b_r;
    end
  end
  assign level = sync_r;
  assign fall = armed_r & prev_r & ~sync_r;
endmodule

// File: verilog/irq_latch.sv
// request latch with edge-only and edge-plus-level modes
`timescale 1ns/10ps
module irq_latch (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic fall,
  input wire logic level,
  input wire logic vector_fetch,
  ext_irq_if.latch ctl
);
  ext_irq_pkg::latch_state_e state_r;
  ext_irq_pkg::latch_state_e state_nxt;
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ext_irq_pkg::st_idle: begin
        if (fall) begin
          state_nxt = ext_irq_pkg::st_pending;
        end
      end
      ext_irq_pkg::st_pending: begin
        if ((ctl.ack || vector_fetch) && !fall) begin
          // level mode holds the request while the pin is low
          if (ctl.mode && !level) begin
            state_nxt = ext_irq_pkg::st_wait_high;
          end else begin
            state_nxt = ext_irq_pkg::st_idle;
          end
        end
      end
      ext_irq_pkg::st_wait_high: begin
        if (!ctl.mode || level) begin
          state_nxt = fall ? ext_irq_pkg::st_pending : ext_irq_pkg::st_idle;
        end
      end
      default: state_nxt = ext_irq_pkg::st_idle;
    endcase
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= ext_irq_pkg::st_idle;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign ctl.pending = (state_r != ext_irq_pkg::st_idle);
endmodule

// File: test/ext_irq_monitor.sv
// checker: port timing of the external interrupt unit
`timescale 1ns/10ps
module ext_irq_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic irq_pin_n,
  input wire logic vector_fetch,
  input wire logic global_mask,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic cpu_irq_req,
  input wire logic [15:0] cpu_vector_addr,
  input wire logic pin_level
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_vec; cpu_vector_addr == 16'hfffa; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_gm; global_mask |=> !cpu_irq_req; endproperty
  a_gm: assert property (p_gm) else $error("request past cpu mask");
  property p_lo; !irq_pin_n [*5] |-> !pin_level; endproperty
  a_lo: assert property (p_lo) else $error("pin level not low");
  property p_hi; irq_pin_n [*5] |-> pin_level; endproperty
  a_hi: assert property (p_hi) else $error("pin level not high");
  // pin quiet before the fetch, so nothing can relatch inside the window
  property p_vf; irq_pin_n [*4] ##0 vector_fetch |-> ##[1:4] !cpu_irq_req; endproperty
  a_vf: assert property (p_vf) else $error("fetch did not clear");
  property p_rst; $fell(rst) |-> !cpu_irq_req [*8]; endproperty
  a_rst: assert property (p_rst) else $error("request after reset");
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_end; pready |=> !pready; endproperty
  a_end: assert property (p_end) else $error("ready held too long");
endmodule
bind ext_irq_top ext_irq_monitor u_mon (.*);

// File: test/irq_source.sv
// partner: external interrupt source on the active-low pin
`timescale 1ns/10ps
module irq_source (
  input wire logic pull_low,
  output logic pin_n
);
  // pullup on the pin: released means high
  assign pin_n = pull_low ? 1'b0 : 1'b1;
endmodule

// File: test/external_interrupt_latch_test.sv
// testbench: registers, latch modes and interrupts of the external interrupt unit
`timescale 1ns/10ps
module external_interrupt_latch_test;
  logic ref_clk = 0, rst = 1, low = 0, vf = 0, brk = 0, gm = 0, err;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, req, lvl, irq, pin_n;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [15:0] vaddr;
  int bad_count = 0, checks_done = 0;
  always #5 ref_clk = ~ref_clk;
  irq_source u_src (.pull_low(low), .pin_n(pin_n));
  ext_irq_top u_dut (.ref_clk(ref_clk), .rst(rst), .irq_pin_n(pin_n), .vector_fetch(vf),
    .break_state(brk), .global_mask(gm), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_irq_req(req), .cpu_vector_addr(vaddr), .pin_level(lvl), .irq(irq));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one idle cycle after each transfer keeps drivers from double assignment
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1;
    // no own limit: only the watchdog ends a hung wait
    do begin
      tick(1);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    tick(1);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    bus(0, a, 32'h0000_0000);
    chk(rd, e);
  endtask
  task automatic pulse;
    low <= 1;
    tick(2);
    low <= 0;
    tick(6);
  endtask
  initial begin
    tick(4);
    rst <= 0;
    tick(1);
    rdc(12'h000, 32'h0000_0000);
    rdc(12'h00c, 32'h0000_0000);
    rdc(12'h010, 32'h0000_fffa);
    chk(vaddr, 32'h0000_fffa);
    rdc(12'h020, 32'h0000_0000);
    chk(err, 32'h0000_0001);
    chk(lvl, 32'h0000_0001);
    $display("test reset values done");
    pulse();
    rdc(12'h000, 32'h0000_0008);
    chk(req, 32'h0000_0001);
    bus(1, 12'h000, 32'h0000_0004);
    rdc(12'h000, 32'h0000_0000);
    pulse();
    rdc(12'h000, 32'h0000_0008);
    bus(1, 12'h000, 32'h0000_0002);
    tick(2);
    chk(req, 32'h0000_0000);
    rdc(12'h000, 32'h0000_000a);
    bus(1, 12'h000, 32'h0000_0000);
    tick(2);
    chk(req, 32'h0000_0001);
    gm <= 1;
    tick(2);
    chk(req, 32'h0000_0000);
    gm <= 0;
    vf <= 1;
    tick(1);
    vf <= 0;
    tick(2);
    rdc(12'h000, 32'h0000_0000);
    rdc(12'h004, 32'h0000_0003);
    bus(1, 12'h008, 32'h0000_0001);
    tick(1);
    chk(irq, 32'h0000_0001);
    bus(1, 12'h004, 32'h0000_0003);
    tick(1);
    chk(irq, 32'h0000_0000);
    bus(1, 12'h008, 32'h0000_0000);
    pulse();
    chk(irq, 32'h0000_0000);
    $display("test edge mode done");
    bus(1, 12'h000, 32'h0000_0005);
    low <= 1;
    tick(6);
    chk(lvl, 32'h0000_0000);
    bus(1, 12'h000, 32'h0000_0005);
    rdc(12'h000, 32'h0000_0009);
    low <= 0;
    tick(6);
    rdc(12'h000, 32'h0000_0001);
    pulse();
    rdc(12'h000, 32'h0000_0009);
    bus(1, 12'h000, 32'h0000_0005);
    rdc(12'h000, 32'h0000_0001);
    $display("test level mode done");
    bus(1, 12'h000, 32'h0000_0000);
    pulse();
    brk <= 1;
    bus(1, 12'h000, 32'h0000_0004);
    rdc(12'h000, 32'h0000_0008);
    bus(1, 12'h00c, 32'h0000_0001);
    rdc(12'h00c, 32'h0000_0001);
    bus(1, 12'h000, 32'h0000_0004);
    brk <= 0;
    rdc(12'h000, 32'h0000_0000);
    bus(1, 12'h000, 32'h0000_0001);
    low <= 1;
    tick(6);
    rst <= 1;
    tick(2);
    rst <= 0;
    tick(6);
    rdc(12'h000, 32'h0000_0000);
    low <= 0;
    $display("test break and reset done");
    end_of_test();
  end
  initial begin
    #50us;
    $display("unexpected at %0t: watchdog expired", $time);
    bad_count++;
    end_of_test();
  end
endmodule
